// file: core/sfsr_params.svh
`ifndef SFSR_PARAMS_SVH
`define SFSR_PARAMS_SVH
// Opcodes
`define SFSR_OP_RD_STAT_LO 8'h05
`define SFSR_OP_RD_STAT_HI 8'h35
`define SFSR_OP_WR_STAT 8'h01
`define SFSR_OP_WR_EN 8'h06
`define SFSR_OP_WR_EN_VOL 8'h50
`define SFSR_OP_WR_DIS 8'h04
`define SFSR_OP_READ 8'h03
`define SFSR_OP_FAST 8'h0B
`define SFSR_OP_DUAL 8'h3B
`define SFSR_OP_QUAD 8'h6B
// Rising-edge counts within a frame
`define SFSR_CNT_OPCODE 6'h08
`define SFSR_CNT_ADDR 6'h20
`define SFSR_CNT_DUMMY 6'h28
`define SFSR_CNT_WR_ONE 6'h10
`define SFSR_CNT_WR_TWO 6'h18
`define SFSR_CNT_SAT 6'h3F
// Status field layout
`define SFSR_LO_WR_MASK 8'hFC
`define SFSR_HI_WR_MASK 8'h7B
`define SFSR_HI_OTP_NV 8'h38
`define SFSR_HI_OTP_VOL 8'h39
`define SFSR_HI_SHORT_CLR 8'h42
`define SFSR_HI_QE_BIT 1
`define SFSR_LO_BUSY_BIT 0
`define SFSR_LO_WEL_BIT 1
`define SFSR_STATUS_FACTORY 8'h00
// Timing
`define SFSR_CLK_NS 100
`define SFSR_TW_NS 10000000
`endif

// file: core/sfsr_pkg.sv
package sfsr_pkg;
	// What the current frame is doing on the link
	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_STAT_LO,
		MODE_STAT_HI,
		MODE_READ,
		MODE_FAST,
		MODE_DUAL,
		MODE_QUAD,
		MODE_OTHER
	} sfsr_mode_type;
endpackage

// file: core/sfsr_core.sv
// Behaviour
// - Opcodes 05h/35h select status read, rising edges
// - Status byte out MSB first on falling edges
// - Status reads accepted even while busy
// - Status byte repeats until chip select rises
// - 01h changes only writable status bits
// - Lock bits never cleared; high protect kept only by volatile writes
// - Non-volatile write needs write enable latch set
// - After 50h with the write enable latch clear, only volatile copies change
// - Write ends only after 8 or 16 bits
// - Eight-bit write clears complement and quad enable
// - Non-volatile write: busy for write time, latch cleared
// - Volatile write applies quickly, busy stays 0
// - Power-up reloads stored values, factory zero
// - 03h plus 24-bit address, MSB first
// - Bytes stream with address increment until deselect
// - Reads while busy are ignored
// - 0Bh adds eight dummy clocks
// - 3Bh returns two bits per clock
// - 6Bh quad read needs quad enable
// - Dual: line 1 odd bits, line 0 even
// - Quad: one nibble per clock, high first
`timescale 1ns/1ns
`default_nettype none
`include "sfsr_params.svh"
module sfsr_core #(
	parameter int MEM_AW = 22,
	parameter int TW_NS = `SFSR_TW_NS
) (
	// System side
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// Array preload port, use only while deselected
	input wire logic pre_we,
	input wire logic [MEM_AW-1:0] pre_addr,
	input wire logic [7:0] pre_data,
	// Serial link
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe
);
	localparam int TW_CYC = (TW_NS + `SFSR_CLK_NS - 1) / `SFSR_CLK_NS;

	// ---- System domain state ----
	logic cs_s1, cs_s2, cs_d;
	logic [7:0] nv_lo = `SFSR_STATUS_FACTORY; // Factory state of the store
	logic [7:0] nv_hi = `SFSR_STATUS_FACTORY;
	logic [7:0] act_lo, act_hi, next_act_lo, next_act_hi;
	logic [7:0] next_nv_lo, next_nv_hi;
	logic write_enable_latch, next_wel, vwe, next_vwe, busy, next_busy;
	logic [23:0] timer, next_timer;
	logic [15:0] stat_word, next_stat_word;
	logic frame_end, wr_ok_len, nv_commit, vol_commit;
	logic [7:0] d_lo, d_hi;
	logic [7:0] mem [0:(1<<MEM_AW)-1];

	// ---- Link domain state ----
	logic in_active;
	logic [5:0] cnt, next_cnt;
	logic [31:0] sh, next_sh;
	logic [7:0] opcode, next_opcode;
	logic [23:0] addr, next_addr;
	logic [15:0] wdat, next_wdat;
	sfsr_pkg::sfsr_mode_type mode, next_mode;
	logic [15:0] st_s1, st_s2;
	logic [7:0] rx_op;
	logic [7:0] osr, next_osr;
	logic [2:0] beat, next_beat;
	logic [23:0] rd_addr, next_rd_addr;
	logic out_on, next_out_on;
	logic [3:0] next_io_out, next_io_oe;

	// Chip select is a pin for the system clock, so two flops first
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_d <= 1'b1;
		end
		else if (ce)
		begin
			cs_s1 <= cs_n;
			cs_s2 <= cs_s1;
			cs_d <= cs_s2;
		end
	end

	// Link summary regs are frozen once the frame has ended and sck stops
	assign frame_end = cs_s2 & ~cs_d;
	assign wr_ok_len = (cnt == `SFSR_CNT_WR_ONE) | (cnt == `SFSR_CNT_WR_TWO);
	assign nv_commit = frame_end & ~busy & (opcode == `SFSR_OP_WR_STAT) & wr_ok_len
		& write_enable_latch;
	assign vol_commit = frame_end & ~busy & (opcode == `SFSR_OP_WR_STAT) & wr_ok_len
		& ~write_enable_latch & vwe;

	// Data bytes: short write keeps the high byte but drops two fields
	always_comb
	begin
		if (cnt == `SFSR_CNT_WR_ONE)
		begin
			d_lo = wdat[7:0];
			d_hi = act_hi & ~`SFSR_HI_SHORT_CLR;
		end
		else
		begin
			d_lo = wdat[15:8];
			d_hi = wdat[7:0];
		end
	end

	// Status update: only writable bits move, OTP bits only ever set
	always_comb
	begin
		next_act_lo = act_lo;
		next_act_hi = act_hi;
		next_nv_lo = nv_lo;
		next_nv_hi = nv_hi;
		next_wel = write_enable_latch;
		next_vwe = vwe;
		next_busy = busy;
		next_timer = timer;
		if (busy)
		begin
			if (timer == 24'h000000)
			begin
				next_busy = 1'b0;
				next_wel = 1'b0;
			end
			else
				next_timer = timer - 24'h000001;
		end
		else if (nv_commit)
		begin
			next_act_lo = (act_lo & ~`SFSR_LO_WR_MASK) | (d_lo & `SFSR_LO_WR_MASK);
			next_act_hi = ((act_hi & ~`SFSR_HI_WR_MASK) | (d_hi & `SFSR_HI_WR_MASK))
				| (act_hi & `SFSR_HI_OTP_NV);
			next_nv_lo = next_act_lo;
			next_nv_hi = next_act_hi;
			next_busy = 1'b1;
			next_timer = 24'(TW_CYC - 1);
			next_vwe = 1'b0;
		end
		else if (vol_commit)
		begin
			// Applied one cycle after deselect is seen, well inside the interval
			next_act_lo = (act_lo & ~`SFSR_LO_WR_MASK) | (d_lo & `SFSR_LO_WR_MASK);
			next_act_hi = ((act_hi & ~`SFSR_HI_WR_MASK) | (d_hi & `SFSR_HI_WR_MASK))
				| (act_hi & `SFSR_HI_OTP_VOL);
			next_vwe = 1'b0;
		end
		else if (frame_end & (cnt == `SFSR_CNT_OPCODE))
		begin
			if (opcode == `SFSR_OP_WR_EN)
				next_wel = 1'b1;
			else if (opcode == `SFSR_OP_WR_EN_VOL)
				next_vwe = 1'b1;
			else if (opcode == `SFSR_OP_WR_DIS)
			begin
				next_wel = 1'b0;
				next_vwe = 1'b0;
			end
		end
		// Any other ending, including an unenabled write, changes nothing
		next_stat_word = {next_act_hi, next_act_lo[7:2], next_wel, next_busy};
	end

	// Reset reloads the active copy from the store, which survives it
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			act_lo <= nv_lo;
			act_hi <= nv_hi;
			write_enable_latch <= 1'b0;
			vwe <= 1'b0;
			busy <= 1'b0;
			timer <= 24'h000000;
			stat_word <= {nv_hi, nv_lo[7:2], 2'h0};
		end
		else if (ce)
		begin
			act_lo <= next_act_lo;
			act_hi <= next_act_hi;
			nv_lo <= next_nv_lo;
			nv_hi <= next_nv_hi;
			write_enable_latch <= next_wel;
			vwe <= next_vwe;
			busy <= next_busy;
			timer <= next_timer;
			stat_word <= next_stat_word;
		end
	end

	// Array preload, written on clk and read on the link clock
	always_ff @(posedge clk)
	begin
		if (ce && pre_we)
			mem[pre_addr] <= pre_data;
	end

	// Status word into the link domain; apart from busy and the write enable latch, both cleared as the write time ends, it changes only
	// between frames, so per-bit synchronising cannot tear a byte in use
	always_ff @(posedge sck)
	begin
		st_s1 <= stat_word;
		st_s2 <= st_s1;
	end

	// Frame marker, cleared the moment chip select rises
	always_ff @(posedge sck or posedge cs_n)
	begin
		if (cs_n)
			in_active <= 1'b0;
		else
			in_active <= 1'b1;
	end

	// Receive: opcode, address and write data shifted in on rising edges
	assign rx_op = {sh[6:0], io_in[0]};
	always_comb
	begin
		next_cnt = in_active ? ((cnt == `SFSR_CNT_SAT) ? cnt : cnt + 6'h01) : 6'h01;
		next_sh = {sh[30:0], io_in[0]};
		next_opcode = opcode;
		next_addr = addr;
		next_wdat = wdat;
		if (next_cnt == `SFSR_CNT_OPCODE)
			next_opcode = rx_op;
		if (next_cnt == `SFSR_CNT_ADDR)
			next_addr = {sh[22:0], io_in[0]};
		if (next_cnt <= `SFSR_CNT_WR_TWO)
			next_wdat = {wdat[14:0], io_in[0]};
	end

	// Counts and captures hold after deselect for the system side
	always_ff @(posedge sck)
	begin
		cnt <= next_cnt;
		sh <= next_sh;
		opcode <= next_opcode;
		addr <= next_addr;
		wdat <= next_wdat;
	end

	// Decode at the eighth edge; status reads never look at busy
	always_comb
	begin
		next_mode = mode;
		if (next_cnt == `SFSR_CNT_OPCODE)
		begin
			case (rx_op)
				`SFSR_OP_RD_STAT_LO: next_mode = sfsr_pkg::MODE_STAT_LO;
				`SFSR_OP_RD_STAT_HI: next_mode = sfsr_pkg::MODE_STAT_HI;
				`SFSR_OP_READ: next_mode = st_s2[`SFSR_LO_BUSY_BIT] ? sfsr_pkg::MODE_OTHER
					: sfsr_pkg::MODE_READ;
				`SFSR_OP_FAST: next_mode = st_s2[`SFSR_LO_BUSY_BIT] ? sfsr_pkg::MODE_OTHER
					: sfsr_pkg::MODE_FAST;
				`SFSR_OP_DUAL: next_mode = st_s2[`SFSR_LO_BUSY_BIT] ? sfsr_pkg::MODE_OTHER
					: sfsr_pkg::MODE_DUAL;
				`SFSR_OP_QUAD: next_mode = (st_s2[`SFSR_LO_BUSY_BIT]
					| ~st_s2[8 + `SFSR_HI_QE_BIT]) ? sfsr_pkg::MODE_OTHER
					: sfsr_pkg::MODE_QUAD;
				default: next_mode = sfsr_pkg::MODE_OTHER;
			endcase
		end
	end

	// Mode is dropped by deselect so a new frame starts from decode
	always_ff @(posedge sck or posedge cs_n)
	begin
		if (cs_n)
			mode <= sfsr_pkg::MODE_IDLE;
		else
			mode <= next_mode;
	end

	// Transmit on falling edges; the lane count sets beats per byte.
	// Line 0 is only driven once data starts, after the host released it.
	always_comb
	begin
		logic go;
		logic [7:0] byte_in;
		logic [2:0] last_beat;
		logic [3:0] lanes_oe;
		go = 1'b0;
		byte_in = mem[rd_addr[MEM_AW-1:0]];
		last_beat = 3'h7; // Single lane needs eight beats per byte
		lanes_oe = 4'h2;
		next_osr = osr;
		next_beat = beat;
		next_rd_addr = rd_addr;
		next_out_on = out_on;
		next_io_out = io_out;
		next_io_oe = io_oe;
		case (mode)
			sfsr_pkg::MODE_STAT_LO:
			begin
				go = (cnt == `SFSR_CNT_OPCODE);
				byte_in = st_s2[7:0];
			end
			sfsr_pkg::MODE_STAT_HI:
			begin
				go = (cnt == `SFSR_CNT_OPCODE);
				byte_in = st_s2[15:8];
			end
			sfsr_pkg::MODE_READ: go = (cnt == `SFSR_CNT_ADDR);
			sfsr_pkg::MODE_FAST: go = (cnt == `SFSR_CNT_DUMMY);
			sfsr_pkg::MODE_DUAL:
			begin
				go = (cnt == `SFSR_CNT_DUMMY);
				last_beat = 3'h3;
				lanes_oe = 4'h3;
			end
			sfsr_pkg::MODE_QUAD:
			begin
				go = (cnt == `SFSR_CNT_DUMMY);
				last_beat = 3'h1;
				lanes_oe = 4'hF;
			end
			default: go = 1'b0;
		endcase
		if (go)
			next_rd_addr = addr;
		if (go || (out_on && beat == last_beat))
		begin
			// New byte: status repeats, array address steps on
			if (go && mode != sfsr_pkg::MODE_STAT_LO && mode != sfsr_pkg::MODE_STAT_HI)
				byte_in = mem[addr[MEM_AW-1:0]];
			next_rd_addr = (go ? addr : rd_addr) + 24'h000001;
			next_osr = byte_in;
			next_beat = 3'h0;
			next_out_on = 1'b1;
		end
		else if (out_on)
			next_beat = beat + 3'h1;
		if (go || out_on)
		begin
			if (lanes_oe == 4'hF)
				next_io_out = (next_beat == 3'h0) ? next_osr[7:4] : next_osr[3:0];
			else if (lanes_oe == 4'h3)
				next_io_out = {2'h0, next_osr[3'h7 - {next_beat[1:0], 1'b0}],
					next_osr[3'h6 - {next_beat[1:0], 1'b0}]};
			else
				next_io_out = {2'h0, next_osr[3'h7 - next_beat], 1'b0};
			next_io_oe = lanes_oe;
		end
	end

	// Output registers; deselect clears them at once, without waiting for sck
	always_ff @(negedge sck or posedge cs_n)
	begin
		if (cs_n)
		begin
			osr <= 8'h00;
			beat <= 3'h0;
			rd_addr <= 24'h000000;
			out_on <= 1'b0;
			io_out <= 4'h0;
			io_oe <= 4'h0;
		end
		else
		begin
			osr <= next_osr;
			beat <= next_beat;
			rd_addr <= next_rd_addr;
			out_on <= next_out_on;
			io_out <= next_io_out;
			io_oe <= next_io_oe;
		end
	end

	// Checks on the system side
	a_busy_span: assert property (@(posedge clk) disable iff (srst)
		nv_commit && ce |=> busy && timer == 24'(TW_CYC - 1))
		else $error("busy not started with full write time");
	a_wel_drop: assert property (@(posedge clk) disable iff (srst)
		$fell(busy) |-> !write_enable_latch)
		else $error("write enable latch survived write cycle");
	a_lock_keep: assert property (@(posedge clk) disable iff (srst)
		ce |=> ((($past(act_hi) & `SFSR_HI_OTP_NV) & ~act_hi) == 8'h00))
		else $error("lock bit cleared");
	a_vol_quiet: assert property (@(posedge clk) disable iff (srst)
		vol_commit && ce |=> !busy && !write_enable_latch)
		else $error("volatile write raised busy or latch");
	a_short_clear: assert property (@(posedge clk) disable iff (srst)
		(nv_commit || vol_commit) && ce && cnt == `SFSR_CNT_WR_ONE
		|=> (act_hi & `SFSR_HI_SHORT_CLR & ~`SFSR_HI_OTP_VOL) == 8'h00)
		else $error("short write kept complement or quad enable");
	a_no_enable: assert property (@(posedge clk) disable iff (srst)
		frame_end && ce && !busy && !write_enable_latch && !vwe |=> $stable(act_lo) && $stable(act_hi))
		else $error("unenabled write changed status");
	a_bad_len: assert property (@(posedge clk) disable iff (srst)
		frame_end && ce && !wr_ok_len && !busy |=> $stable(act_lo) && !busy)
		else $error("status write at wrong length took effect");
	a_ro_mask: assert property (@(posedge clk) disable iff (srst)
		ce |=> ((act_hi ^ $past(act_hi)) & ~`SFSR_HI_WR_MASK) == 8'h00)
		else $error("read-only high status bit changed");
	// Checks on the link side
	a_quad_gate: assert property (@(negedge sck) disable iff (cs_n)
		io_oe == 4'hF |-> st_s2[8 + `SFSR_HI_QE_BIT])
		else $error("quad output without quad enable");
	a_dual_lanes: assert property (@(negedge sck) disable iff (cs_n)
		mode == sfsr_pkg::MODE_DUAL && out_on |-> io_oe == 4'h3)
		else $error("dual read not on two lines");
endmodule
`default_nettype wire

// file: verif/sfsr_host.sv
`timescale 1ns/1ns
`default_nettype none
module sfsr_host (
	// Device drive
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe,
	// Link
	output logic sck,
	output logic cs_n,
	output logic [3:0] io_in
);
	logic [3:0] hd = 4'h5;
	// Link clock stands still between frames; a power-on deselect edge
	// puts the device's link side in a known state before the first frame
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b0;
		#20 cs_n = 1'b1;
	end
	// Undriven lanes show a moving pattern so a stale value never passes
	assign io_in = (io_oe & io_out) | (~io_oe & hd);
	// One frame: ntx bits out on line 0, then nrx clocks sampled on ln lanes
	task automatic frame(input logic [47:0] tx, input int ntx, input int nrx, input int ln,
		output logic [31:0] rx, output logic [3:0] oe);
		rx = 32'h0;
		oe = 4'h0;
		cs_n = 1'b0;
		for (int i = 0; i < ntx; i++)
		begin
			hd = {~hd[3:1], tx[ntx-1-i]};
			#40 sck = 1'b1;
			#20 if (i == ntx - 1) hd = ~hd;
			#20 sck = 1'b0;
		end
		for (int i = 0; i < nrx; i++)
		begin
			#40 sck = 1'b1;
			// Line levels, so a lane the device forgot to enable shows the host pattern
			rx = (ln == 1) ? {rx[30:0], io_in[1]} : (ln == 2) ? {rx[29:0], io_in[1:0]} :
				{rx[27:0], io_in};
			oe = oe | io_oe;
			#20 hd = ~hd;
			#20 sck = 1'b0;
		end
		#40 cs_n = 1'b1;
		// Gap lets the system side take the frame summary
		#600;
	endtask
endmodule
`default_nettype wire

// file: verif/sfsr_core_test.sv
`timescale 1ns/1ns
`default_nettype none
module sfsr_core_test;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic pre_we = 1'b0;
	logic [7:0] pre_addr = 8'h00;
	logic [7:0] pre_data = 8'h00;
	logic sck, cs_n;
	logic [3:0] io_in, io_out, io_oe, oe;
	logic [31:0] rx;
	logic [31:0] seed = 32'h0000002F;
	logic [7:0] mem [256];
	logic [7:0] vlo = 8'h00, vhi = 8'h00, nlo = 8'h00, nhi = 8'h00, d1, d2;
	logic [7:0] ops [4] = '{8'h03, 8'h0B, 8'h3B, 8'h6B};
	logic [3:0] oes [4] = '{4'h2, 4'h2, 4'h3, 4'hF};
	int lns [4] = '{1, 1, 2, 4};
	int errors = 0;
	int checks = 0;
	// Short write time keeps the busy window near 20 cycles
	sfsr_core #(.MEM_AW(8), .TW_NS(2000)) dut_u (.clk(clk), .srst(srst), .ce(1'b1),
		.pre_we(pre_we), .pre_addr(pre_addr), .pre_data(pre_data), .sck(sck), .cs_n(cs_n),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe));
	sfsr_host host_u (.io_out(io_out), .io_oe(io_oe), .sck(sck), .cs_n(cs_n), .io_in(io_in));
	// System clock
	always #50 clk = ~clk;
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Status model; lock bits cannot fall once set, high protect only across volatile writes
	task automatic wr(input logic [7:0] a, input logic [7:0] b, input logic vol);
		vhi = (b & 8'h7B) | (vhi & (vol ? 8'h39 : 8'h38));
		vlo = a & 8'hFC;
		if (!vol)
		begin
			nlo = vlo;
			nhi = vhi;
		end
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic op8(input logic [7:0] op);
		host_u.frame({40'h0, op}, 8, 0, 1, rx, oe);
	endtask
	task automatic wst(input logic [7:0] a, input logic [7:0] b, input int nb);
		host_u.frame({24'h0, 8'h01, a, b} >> (16 - nb), 8 + nb, 0, 1, rx, oe);
	endtask
	// Two bytes read back must be the same status byte twice
	task automatic rds(input logic hi, input logic [7:0] e);
		host_u.frame({40'h0, hi ? 8'h35 : 8'h05}, 8, 16, 1, rx, oe);
		chk(rx, {16'h0, e, e});
		chk(32'(oe), 32'h2);
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial
	begin
		#3000000;
		errors++;
		conclude();
	end
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 256; i++)
		begin
			@(posedge clk);
			d1 = rnd();
			mem[i] = d1;
			pre_we <= 1'b1;
			pre_addr <= 8'(i);
			pre_data <= d1;
		end
		@(posedge clk);
		pre_we <= 1'b0;
		#1000;
		rds(0, 8'h00);
		rds(1, 8'h00);
		done("reset");
		wst(8'hFF, 8'hFF, 16);
		rds(0, 8'h00);
		rds(1, 8'h00);
		op8(8'h06);
		rds(0, 8'h02);
		d1 = rnd();
		d2 = rnd() | 8'h02;
		wst(d1, d2, 16);
		wr(d1, d2, 1'b0);
		host_u.frame({40'h0, 8'h05}, 8, 8, 1, rx, oe);
		chk(32'(rx[1:0]), 32'h3);
		#3000;
		rds(0, vlo);
		rds(1, vhi);
		op8(8'h06);
		d1 = rnd();
		d2 = rnd() | 8'h02;
		wst(d1, d2, 16);
		wr(d1, d2, 1'b0);
		host_u.frame({16'h0, 8'h03, 24'h0}, 32, 8, 1, rx, oe);
		chk(32'(oe), 32'h0);
		#3000;
		rds(0, vlo);
		rds(1, vhi);
		done("nv write");
		for (int k = 0; k < 4; k++)
		begin
			host_u.frame({8'h00, ops[k], 24'hFFFFFE, 8'h00} >> (k ? 0 : 8), k ? 40 : 32, 32 / lns[k],
				lns[k], rx, oe);
			chk(rx, {mem[254], mem[255], mem[0], mem[1]});
			chk(32'(oe), 32'(oes[k]));
			chk(32'(io_oe), 32'h0);
		end
		done("reads");
		op8(8'h50);
		d1 = rnd();
		wst(d1, 8'h00, 8);
		wr(d1, vhi & 8'hBD, 1'b1);
		rds(0, vlo);
		rds(1, vhi);
		host_u.frame({8'h00, 8'h6B, 32'h0}, 40, 8, 4, rx, oe);
		chk(32'(oe), 32'h0);
		op8(8'h50);
		d1 = rnd();
		wst(d1, 8'h00, 16);
		wr(d1, 8'h00, 1'b1);
		rds(0, vlo);
		rds(1, vhi);
		done("volatile");
		op8(8'h06);
		wst(rnd(), rnd(), 12);
		rds(0, vlo | 8'h02);
		rds(1, vhi);
		op8(8'h04);
		rds(0, vlo);
		done("length");
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		#1000;
		rds(0, nlo);
		rds(1, nhi);
		done("reload");
		conclude();
	end
endmodule
`default_nettype wire
